/* File: sdp_regs.vh */
// Behaviour
// - three data registers, operand register, serial adder, carry, operand selectors
// - words move one bit per bit time; each operation finishes whole word
// - data registers recirculate; only the destination takes new bits
// - first operand is a data register or zero; second is operand or jump
// - result goes to chosen registers and out serially on data_out
// - least-bit flag follows first result bit
// - most-bit flag follows eighth result bit
// - all-ones flag set only if all eight result bits are one
// - overflow flag reports add overflow; logic ops force a preset value
// - program counter is eight bits, advances by one or two
// - jump register holds a target that replaces the counted address
// - program counter addresses the next microinstruction read
// - microprogram store holds 256 words of 12 bits
// - run and load modes from an external switch; run fetches from the store
// - load mode fetches a 32-word boot program and takes bus writes to the store
// - next address is counter plus one, plus two, or jump register
// - literals to operand register are inverted; jump literals are not
// - clear input forces the program counter to zero
`ifndef SDP_REGS_VH
`define SDP_REGS_VH

// register byte offsets
`define SDP_OFF_OP       8'h00
`define SDP_OFF_STATUS   8'h04
`define SDP_OFF_LITERAL  8'h08
`define SDP_OFF_SEQ      8'h0c
`define SDP_OFF_PC       8'h10
`define SDP_OFF_DATA     8'h14
`define SDP_OFF_JUMP     8'h18
`define SDP_OFF_STORE    8'h1c

// operation register fields
`define SDP_OP_SRC1_LO   0
`define SDP_OP_SRC1_HI   1
`define SDP_OP_SRC2      2
`define SDP_OP_DEST_LO   3
`define SDP_OP_DEST_HI   7
`define SDP_OP_FN_LO     8
`define SDP_OP_FN_HI     9
`define SDP_OP_OVPRE     10

// adder functions
`define SDP_FN_ADD       2'h0
`define SDP_FN_AND       2'h1
`define SDP_FN_OR        2'h2
`define SDP_FN_XOR       2'h3

// first operand selections
`define SDP_SRC1_ZERO    2'h0
`define SDP_SRC1_FIRST   2'h1
`define SDP_SRC1_SECOND  2'h2
`define SDP_SRC1_THIRD   2'h3

// destination mask bits
`define SDP_DST_FIRST    0
`define SDP_DST_SECOND   1
`define SDP_DST_THIRD    2
`define SDP_DST_OPERAND  3
`define SDP_DST_JUMP     4

// literal register fields
`define SDP_LIT_TO_JUMP  8
`define SDP_LIT_AND_PC   9

// successor selections
`define SDP_SUCC_STEP    2'h0
`define SDP_SUCC_SKIP    2'h1
`define SDP_SUCC_JUMP    2'h2

// sizes and reset values
`define SDP_WORD_W       8
`define SDP_INSTR_W      12
`define SDP_STORE_DEPTH  256
`define SDP_BOOT_DEPTH   32
`define SDP_BOOT_AW      5
`define SDP_BIT_DIV      10
`define SDP_BIT_LAST     3'h7
`define SDP_PC_RESET     8'h00

`endif

/* File: sdp_shift_reg.v */
`timescale 1ns/100ps
`include "sdp_regs.vh"

// recirculating shift register, least bit leaves first
module sdp_shift_reg #(
   parameter WIDTH = `SDP_WORD_W
) (
   // clock and reset
   input wire hclk,
   input wire hresetn,
   // parallel load
   input wire load_en,
   input wire [WIDTH-1:0] load_val,
   // serial side
   input wire shift_en,
   input wire dest_en,
   input wire in_bit,
   output wire out_bit,
   output reg [WIDTH-1:0] q
);

   assign out_bit = q[0];

   // rotate or take the new result bit at the top
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= {WIDTH{1'b0}};
      end else if (load_en) begin
         q <= load_val;
      end else if (shift_en) begin
         q <= {(dest_en ? in_bit : q[0]), q[WIDTH-1:1]};
      end
   end

endmodule // sdp_shift_reg

/* File: sdp_store.v */
`timescale 1ns/100ps
`include "sdp_regs.vh"

// read-write microprogram store plus fixed boot program
module sdp_store #(
   parameter DEPTH = `SDP_STORE_DEPTH,
   parameter WIDTH = `SDP_INSTR_W
) (
   // clock
   input wire hclk,
   // fetch side
   input wire [7:0] addr,
   input wire load_mode,
   output wire [WIDTH-1:0] instr,
   // write side
   input wire wr_en,
   input wire [WIDTH-1:0] wr_data
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [WIDTH-1:0] boot_word;

   // boot program image, low address bits only
   always @* begin
      case (addr[`SDP_BOOT_AW-1:0])
         5'h00: boot_word = 12'h000;
         5'h01: boot_word = 12'h0b1;
         5'h02: boot_word = 12'h1f2;
         5'h03: boot_word = 12'h002;
         default: boot_word = 12'h000;
      endcase
   end

   // load mode fetches from the boot program
   assign instr = load_mode ? boot_word : mem[addr];

   // store write, one word per strobe
   always @(posedge hclk) begin
      if (wr_en) begin
         mem[addr] <= wr_data;
      end
   end

endmodule // sdp_store

/* File: sdp_datapath.v */
`timescale 1ns/100ps
`include "sdp_regs.vh"

module sdp_datapath #(
   parameter BIT_DIV = `SDP_BIT_DIV
) (
   // clock and reset
   input wire hclk,
   input wire hresetn,
   // ahb-lite slave
   input wire hsel,
   input wire [7:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output wire [31:0] hrdata,
   // external pins
   input wire counter_clear_in,
   input wire load_mode_in,
   output reg data_out,
   output reg data_out_strobe,
   output wire [7:0] program_counter_out
);

   ////////////////////////////////////////////////////////////////////////
   // declarations

   reg [31:0] hrdata_q;
   reg wr_phase;
   reg [7:0] addr_q;
   reg [10:0] op_ctrl;
   reg busy;
   reg [2:0] bit_idx;
   reg carry;
   reg least_bit_flag;
   reg most_bit_flag;
   reg all_ones_flag;
   reg overflow_flag;
   reg [7:0] program_counter;
   reg [7:0] next_pc;
   reg [3:0] div_cnt;
   reg bit_tick;
   reg [31:0] read_mux;
   reg res_bit;
   reg x_bit;
   reg sum_carry;

   wire [7:0] data_reg_first;
   wire [7:0] data_reg_second;
   wire [7:0] data_reg_third;
   wire [7:0] operand_reg;
   wire [7:0] jump_address_reg;
   wire out_first;
   wire out_second;
   wire out_third;
   wire out_operand;
   wire out_jump;
   wire [11:0] instr;
   wire wr_op;
   wire wr_lit;
   wire wr_seq;
   wire wr_store;
   wire start;
   wire shift_en;
   wire y_bit;
   wire [4:0] dest;
   wire lit_operand;
   wire lit_jump;
   wire [7:0] rd_addr;
   wire rd_take;

   ////////////////////////////////////////////////////////////////////////
   // ahb-lite slave, zero wait states

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // capture the address phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_phase <= 1'b0;
         addr_q <= 8'h00;
      end else if (hready) begin
         wr_phase <= hsel & htrans[1] & hwrite;
         addr_q <= {haddr[7:2], 2'b00};
      end
   end

   // write strobes in the data phase
   assign wr_op = wr_phase && (addr_q == `SDP_OFF_OP);
   assign wr_lit = wr_phase && (addr_q == `SDP_OFF_LITERAL);
   assign wr_seq = wr_phase && (addr_q == `SDP_OFF_SEQ);
   assign wr_store = wr_phase && (addr_q == `SDP_OFF_STORE) && load_mode_in;

   // read decode on the address phase
   assign rd_addr = {haddr[7:2], 2'b00};
   assign rd_take = hsel && htrans[1] && !hwrite;

   // read mux, unmapped reads as zero
   always @* begin
      case (rd_addr)
         `SDP_OFF_OP: read_mux = {21'h000000, op_ctrl};
         `SDP_OFF_STATUS: read_mux = {25'h0000000, load_mode_in, carry, overflow_flag,
            all_ones_flag, most_bit_flag, least_bit_flag, busy};
         `SDP_OFF_PC: read_mux = {12'h000, instr, program_counter};
         `SDP_OFF_DATA: read_mux = {operand_reg, data_reg_third, data_reg_second,
            data_reg_first};
         `SDP_OFF_JUMP: read_mux = {24'h000000, jump_address_reg};
         default: read_mux = 32'h00000000;
      endcase
   end

   // read data from a flop, loaded at the address phase, zero outside a read
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h00000000;
      end else if (hready) begin
         hrdata_q <= rd_take ? read_mux : 32'h00000000;
      end
   end

   assign hrdata = hrdata_q;

   ////////////////////////////////////////////////////////////////////////
   // bit time divider

   // one-cycle tick every BIT_DIV clocks
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_cnt <= 4'h0;
         bit_tick <= 1'b0;
      end else if (div_cnt == BIT_DIV[3:0] - 4'h1) begin
         div_cnt <= 4'h0;
         bit_tick <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 4'h1;
         bit_tick <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // operation control

   assign start = wr_op && !busy;
   assign shift_en = busy && bit_tick;
   assign dest = op_ctrl[`SDP_OP_DEST_HI:`SDP_OP_DEST_LO];

   // eight bit times per operation
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         op_ctrl <= 11'h000;
         busy <= 1'b0;
         bit_idx <= 3'h0;
      end else if (start) begin
         op_ctrl <= hwdata[10:0];
         busy <= 1'b1;
         bit_idx <= 3'h0;
      end else if (shift_en) begin
         bit_idx <= bit_idx + 3'h1;
         if (bit_idx == `SDP_BIT_LAST) begin
            busy <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // serial adder and operand selectors

   // first operand: data register or zero
   always @* begin
      case (op_ctrl[`SDP_OP_SRC1_HI:`SDP_OP_SRC1_LO])
         `SDP_SRC1_FIRST: x_bit = out_first;
         `SDP_SRC1_SECOND: x_bit = out_second;
         `SDP_SRC1_THIRD: x_bit = out_third;
         default: x_bit = 1'b0;
      endcase
   end

   // second operand: operand or jump register
   assign y_bit = op_ctrl[`SDP_OP_SRC2] ? out_jump : out_operand;

   // result bit and carry out
   always @* begin
      sum_carry = 1'b0;
      case (op_ctrl[`SDP_OP_FN_HI:`SDP_OP_FN_LO])
         `SDP_FN_ADD: begin
            res_bit = x_bit ^ y_bit ^ carry;
            sum_carry = (x_bit & y_bit) | (carry & (x_bit ^ y_bit));
         end
         `SDP_FN_AND: res_bit = x_bit & y_bit;
         `SDP_FN_OR: res_bit = x_bit | y_bit;
         default: res_bit = x_bit ^ y_bit;
      endcase
   end

   // carry and condition flags
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         carry <= 1'b0;
         least_bit_flag <= 1'b0;
         most_bit_flag <= 1'b0;
         all_ones_flag <= 1'b0;
         overflow_flag <= 1'b0;
      end else if (start) begin
         carry <= 1'b0;
      end else if (shift_en) begin
         carry <= sum_carry;
         if (bit_idx == 3'h0) begin
            least_bit_flag <= res_bit;
            all_ones_flag <= res_bit;
         end else begin
            all_ones_flag <= all_ones_flag & res_bit;
         end
         if (bit_idx == `SDP_BIT_LAST) begin
            most_bit_flag <= res_bit;
            if (op_ctrl[`SDP_OP_FN_HI:`SDP_OP_FN_LO] == `SDP_FN_ADD) begin
               overflow_flag <= sum_carry;
            end else begin
               overflow_flag <= op_ctrl[`SDP_OP_OVPRE];
            end
         end
      end
   end

   // serial result on the external line
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         data_out <= 1'b0;
         data_out_strobe <= 1'b0;
      end else begin
         data_out_strobe <= shift_en;
         if (shift_en) begin
            data_out <= res_bit;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // data registers

   // literal loads, operand takes the complement
   assign lit_operand = wr_lit && !busy && !hwdata[`SDP_LIT_TO_JUMP];
   assign lit_jump = wr_lit && !busy && hwdata[`SDP_LIT_TO_JUMP];

   sdp_shift_reg #(.WIDTH(`SDP_WORD_W)) u_first (
      .hclk(hclk),
      .hresetn(hresetn),
      .load_en(1'b0),
      .load_val(8'h00),
      .shift_en(shift_en),
      .dest_en(dest[`SDP_DST_FIRST]),
      .in_bit(res_bit),
      .out_bit(out_first),
      .q(data_reg_first));

   sdp_shift_reg #(.WIDTH(`SDP_WORD_W)) u_second (
      .hclk(hclk),
      .hresetn(hresetn),
      .load_en(1'b0),
      .load_val(8'h00),
      .shift_en(shift_en),
      .dest_en(dest[`SDP_DST_SECOND]),
      .in_bit(res_bit),
      .out_bit(out_second),
      .q(data_reg_second));

   sdp_shift_reg #(.WIDTH(`SDP_WORD_W)) u_third (
      .hclk(hclk),
      .hresetn(hresetn),
      .load_en(1'b0),
      .load_val(8'h00),
      .shift_en(shift_en),
      .dest_en(dest[`SDP_DST_THIRD]),
      .in_bit(res_bit),
      .out_bit(out_third),
      .q(data_reg_third));

   sdp_shift_reg #(.WIDTH(`SDP_WORD_W)) u_operand (
      .hclk(hclk),
      .hresetn(hresetn),
      .load_en(lit_operand),
      .load_val(~hwdata[7:0]),
      .shift_en(shift_en),
      .dest_en(dest[`SDP_DST_OPERAND]),
      .in_bit(res_bit),
      .out_bit(out_operand),
      .q(operand_reg));

   sdp_shift_reg #(.WIDTH(`SDP_WORD_W)) u_jump (
      .hclk(hclk),
      .hresetn(hresetn),
      .load_en(lit_jump),
      .load_val(hwdata[7:0]),
      .shift_en(shift_en),
      .dest_en(dest[`SDP_DST_JUMP]),
      .in_bit(res_bit),
      .out_bit(out_jump),
      .q(jump_address_reg));

   ////////////////////////////////////////////////////////////////////////
   // program counter and successor selection

   // clear first, then store write, literal jump, successor
   always @* begin
      next_pc = program_counter;
      if (counter_clear_in) begin
         next_pc = `SDP_PC_RESET;
      end else if (wr_store) begin
         next_pc = program_counter + 8'h01;
      end else if (lit_jump && hwdata[`SDP_LIT_AND_PC]) begin
         next_pc = hwdata[7:0];
      end else if (wr_seq) begin
         case (hwdata[1:0])
            `SDP_SUCC_STEP: next_pc = program_counter + 8'h01;
            `SDP_SUCC_SKIP: next_pc = program_counter + 8'h02;
            `SDP_SUCC_JUMP: next_pc = jump_address_reg;
            default: next_pc = program_counter;
         endcase
      end
   end

   // program counter register
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         program_counter <= `SDP_PC_RESET;
      end else begin
         program_counter <= next_pc;
      end
   end

   assign program_counter_out = program_counter;

   ////////////////////////////////////////////////////////////////////////
   // microprogram store

   sdp_store #(.DEPTH(`SDP_STORE_DEPTH), .WIDTH(`SDP_INSTR_W)) u_store (
      .hclk(hclk),
      .addr(program_counter),
      .load_mode(load_mode_in),
      .instr(instr),
      .wr_en(wr_store),
      .wr_data(hwdata[11:0]));

endmodule // sdp_datapath

/* File: sdp_datapath_props.sv */
`timescale 1ns/100ps
// pin-level checks of the serial datapath
module sdp_datapath_props #(
   parameter BIT_DIV = 10
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // pins
   input wire logic counter_clear_in,
   input wire logic load_mode_in,
   input wire logic data_out,
   input wire logic data_out_strobe,
   input wire logic [7:0] program_counter_out
);
   localparam int LIM = 9 * BIT_DIV + 3;
   logic wr_dp, rd_dp;
   logic [7:0] dp_addr;
   logic [15:0] since_op;
   logic [3:0] strobe_cnt;
   wire op_start = wr_dp && (dp_addr[7:2] == 6'h00);
   ////////////////////////////////////////////////////////////
   // data phase tracking, cycles and bits since an operation start
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_dp <= 1'b0;
         rd_dp <= 1'b0;
         dp_addr <= 8'h00;
         since_op <= 16'hffff;
         strobe_cnt <= 4'h8;
      end else begin
         wr_dp <= hsel && htrans[1] && hready && hwrite;
         rd_dp <= hsel && htrans[1] && hready && !hwrite;
         if (hsel && htrans[1] && hready) dp_addr <= haddr;
         if (op_start) since_op <= 16'h0000;
         else if (since_op != 16'hffff) since_op <= since_op + 16'h0001;
         if (op_start) strobe_cnt <= 4'h0;
         else if (data_out_strobe) strobe_cnt <= strobe_cnt + 4'h1;
      end
   end
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_clear_to_zero: assert property (
      counter_clear_in |=> program_counter_out == 8'h00) else $error("clear missed");
   a_pc_change_cause: assert property (
      !$stable(program_counter_out) |-> $past(counter_clear_in) || $past(wr_dp))
      else $error("pc moved alone");
   a_pc_read_back: assert property (
      rd_dp && dp_addr == 8'h10 |-> hrdata[7:0] == $past(program_counter_out))
      else $error("pc read mismatch");
   a_bus_okay: assert property (
      hreadyout && !hresp) else $error("bus not ready or error response");
   a_seq_step_one: assert property (
      wr_dp && dp_addr == 8'h0c && hwdata[1:0] == 2'h0 && !counter_clear_in
      |=> program_counter_out == $past(program_counter_out) + 8'h01) else $error("step bad");
   a_seq_skip_two: assert property (
      wr_dp && dp_addr == 8'h0c && hwdata[1:0] == 2'h1 && !counter_clear_in
      |=> program_counter_out == $past(program_counter_out) + 8'h02) else $error("skip bad");
   a_strobe_one_cycle: assert property (
      data_out_strobe |=> !data_out_strobe) else $error("strobe too long");
   a_strobe_window: assert property (
      data_out_strobe |-> since_op <= LIM) else $error("strobe outside operation");
   a_eight_bits_only: assert property (
      data_out_strobe |-> strobe_cnt < 4'h8) else $error("more than eight bits");
endmodule // sdp_datapath_props

/* File: sdp_port_model.sv */
`timescale 1ns/100ps
// far-side port device collecting the serial result
module sdp_port_model (
   // clock and control
   input wire logic hclk,
   input wire logic restart,
   // serial result
   input wire logic data_out,
   input wire logic data_out_strobe,
   // collected word
   output logic [7:0] word,
   output logic [3:0] bits
);
   // least bit first, shifted in at the top
   always @(posedge hclk) begin
      if (restart) bits <= 4'h0;
      else if (data_out_strobe) begin
         word <= {data_out, word[7:1]};
         bits <= bits + 4'h1;
      end
   end
endmodule // sdp_port_model

/* File: sdp_datapath_tb.sv */
`timescale 1ns/100ps
module sdp_datapath_tb;
   localparam int BIT_DIV = 2;
   logic hclk, hresetn, hsel, hwrite, counter_clear_in, load_mode_in, restart;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, rd, rd_q;
   wire hready, hreadyout, hresp, data_out, data_out_strobe;
   wire [31:0] hrdata;
   wire [7:0] program_counter_out, port_word;
   wire [3:0] port_bits;
   int num_errors, checks;
   logic [15:0] lfsr;
   logic [7:0] r1, r2, r3, opnd, jmp, pc;
   assign hready = hreadyout;
   sdp_datapath #(.BIT_DIV(BIT_DIV)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .counter_clear_in(counter_clear_in), .load_mode_in(load_mode_in), .data_out(data_out),
      .data_out_strobe(data_out_strobe), .program_counter_out(program_counter_out));
   sdp_port_model port (.hclk(hclk), .restart(restart), .data_out(data_out),
      .data_out_strobe(data_out_strobe), .word(port_word), .bits(port_bits));
   // clock and read data sampled at the edge
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   always @(posedge hclk) rd_q <= hrdata;
   ////////////////////////////////////////////////////////////
   function logic [15:0] next_rand(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function logic [8:0] alu(input logic [1:0] fn, input logic [7:0] x, y, input logic ovp);
      case (fn)
         2'h0: alu = {1'b0, x} + {1'b0, y};
         2'h1: alu = {ovp, x & y};
         2'h2: alu = {ovp, x | y};
         default: alu = {ovp, x ^ y};
      endcase
   endfunction
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task summarize;
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // single word transfer, address phase then data phase
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      #1 rd = rd_q;
   endtask
   task rdr(input logic [7:0] a);
      bus(1'b0, a, 32'h0);
   endtask
   task set_pc(input logic [7:0] v);
      bus(1'b1, 8'h08, {22'h0, 2'h3, v});
      pc = v;
      jmp = v;
   endtask
   ////////////////////////////////////////////////////////////
   // watchdog
   initial begin
      repeat (40000) @(posedge hclk);
      num_errors++;
      summarize;
   end
   // main sequence
   initial begin
      logic [7:0] lit, x, y;
      logic tj;
      logic [10:0] opw;
      logic [8:0] res;
      logic [1:0] sc;
      logic [11:0] seq_tab;
      int n;
      seq_tab = 12'h0b1;
      {hresetn, hsel, hwrite, counter_clear_in, load_mode_in, restart} = 6'h00;
      {haddr, htrans, hwdata} = 42'h0;
      hsize = 3'h2;
      {num_errors, checks} = 0;
      lfsr = 16'h001b;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      rdr(8'h10);
      check("pc_reset", rd[7:0], 8'h00);
      for (int i = 0; i < 40; i++) begin
         lfsr = next_rand(lfsr);
         {tj, lit} = lfsr[8:0];
         lfsr = next_rand(lfsr);
         opw = lfsr[10:0];
         if (i == 0) {tj, lit, opw} = {1'b0, 8'h00, 11'h0f8};
         if (i == 1) {tj, lit, opw} = {1'b0, 8'hfe, 11'h011};
         bus(1'b1, 8'h08, {23'h0, tj, lit});
         if (tj) jmp = lit;
         else opnd = ~lit;
         case (opw[1:0])
            2'h0: x = 8'h00;
            2'h1: x = r1;
            2'h2: x = r2;
            default: x = r3;
         endcase
         y = opw[2] ? jmp : opnd;
         res = alu(opw[9:8], x, y, opw[10]);
         @(posedge hclk);
         restart <= 1'b1;
         @(posedge hclk);
         restart <= 1'b0;
         bus(1'b1, 8'h00, {21'h0, opw});
         n = 0;
         do begin
            rdr(8'h04);
            n++;
         end while (rd[0] !== 1'b0 && n < 100);
         if (opw[3]) r1 = res[7:0];
         if (opw[4]) r2 = res[7:0];
         if (opw[5]) r3 = res[7:0];
         if (opw[6]) opnd = res[7:0];
         if (opw[7]) jmp = res[7:0];
         check("flags", rd[4:0], {res[8], &res[7:0], res[7], res[0], 1'b0});
         rdr(8'h14);
         check("data", rd, {opnd, r3, r2, r1});
         rdr(8'h18);
         check("jump", rd[7:0], jmp);
         check("port", {port_bits, port_word}, {4'h8, res[7:0]});
      end
      set_pc(8'hfe);
      rdr(8'h10);
      check("pc_literal", rd[7:0], 8'hfe);
      for (int i = 0; i < 6; i++) begin
         sc = seq_tab[2*i +: 2];
         bus(1'b1, 8'h0c, {30'h0, sc});
         case (sc)
            2'h0: pc = pc + 8'h01;
            2'h1: pc = pc + 8'h02;
            2'h2: pc = jmp;
            default: pc = pc;
         endcase
         rdr(8'h10);
         check("pc_seq", rd[7:0], pc);
      end
      set_pc(8'h5a);
      @(posedge hclk);
      counter_clear_in <= 1'b1;
      @(posedge hclk);
      counter_clear_in <= 1'b0;
      rdr(8'h10);
      check("pc_clear", rd[7:0], 8'h00);
      @(posedge hclk);
      load_mode_in <= 1'b1;
      set_pc(8'hff);
      bus(1'b1, 8'h1c, 32'h00000a5c);
      rdr(8'h10);
      check("pc_load", rd[7:0], 8'h00);
      rdr(8'h04);
      check("mode", rd[6], 1'b1);
      @(posedge hclk);
      load_mode_in <= 1'b0;
      bus(1'b1, 8'h1c, 32'h00000fff);
      rdr(8'h10);
      check("pc_run", rd[7:0], 8'h00);
      set_pc(8'hff);
      rdr(8'h10);
      check("store", rd[19:8], 12'ha5c);
      rdr(8'h20);
      check("unmapped", rd, 32'h0);
      summarize;
   end
endmodule // sdp_datapath_tb
bind sdp_datapath sdp_datapath_props #(.BIT_DIV(BIT_DIV)) u_props (.hclk(hclk),
   .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .counter_clear_in(counter_clear_in), .load_mode_in(load_mode_in),
   .data_out(data_out), .data_out_strobe(data_out_strobe),
   .program_counter_out(program_counter_out));
